// ==== isfm_clk_src.sv ====
`timescale 1ns/100ps
module isfm_clk_src (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Run enables, bit 4 is the oscillator
  input wire logic [4:0] i_run,
  // Source clocks
  output logic [3:0] o_in_clk,
  output logic o_xo_clk
);
  logic [4:0] lvl_reg;
  logic [2:0] cnt_reg;

  // ----------------------------------------
  // Sources: even ones have period 4, odd ones period 6
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
    end
  end

  // A stopped source holds its line low, as a dead clock would
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_reg <= 5'h00;
    end else begin
      for (int k = 0; k < 5; k++) begin
        if (!i_run[k]) begin
          lvl_reg[k] <= 1'h0;
        end else if ((k % 2 == 0) ? cnt_reg[0] : (cnt_reg == 3'h2 || cnt_reg == 3'h5)) begin
          lvl_reg[k] <= ~lvl_reg[k];
        end
      end
    end
  end

  assign o_in_clk = lvl_reg[3:0];
  assign o_xo_clk = lvl_reg[4];
endmodule

// ==== isfm_defines.svh ====
`ifndef ISFM_DEFINES_SVH
`define ISFM_DEFINES_SVH
// Input clocks handled by the selector
`define ISFM_NUM_IN 4
// Select code reserved while zero delay mode is on
`define ISFM_SEL_RESERVED 2'h3
// Index of the feedback input in zero delay mode
`define ISFM_FB_INPUT 2'h3
// Hitless switching lower frequency limit in kHz
`define ISFM_HITLESS_MIN_KHZ 7680
// Largest frequency step for glitchless switching, ppm
`define ISFM_GLITCHLESS_PPM 40
// Precision monitor threshold field: up to 511 ppm in 1/16 ppm steps
`define ISFM_PREC_W 13
`define ISFM_PREC_MAX 13'h1FF0
// Fast monitor threshold limits in ppm
`define ISFM_FAST_W 14
`define ISFM_FAST_MIN 14'h03E8
`define ISFM_FAST_MAX 14'h3E80
// Reference oscillator tolerance and advised least precision threshold, ppm
`define ISFM_XO_TOL_PPM 50
`define ISFM_XO_MIN_THR_PPM 60
// Frequency error inputs are signed, in 1/16 ppm
`define ISFM_ERR_W 20
// Signal-loss sensitivity counter width
`define ISFM_LOS_W 4
// Zero-ppm reference select code for the oscillator
`define ISFM_REFSEL_XO 3'h4
`endif

// ==== isfm_los_mon.sv ====
`timescale 1ns/100ps
`include "isfm_defines.svh"
module isfm_los_mon (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Monitored clock, sampled as a level
  input wire logic i_clk_lvl,
  // Configuration
  input wire logic i_disable,
  input wire logic [7:0] i_period_max,
  input wire logic [`ISFM_LOS_W-1:0] i_miss_tol,
  // Result
  output logic o_loss
);
  logic prev_reg;
  logic [7:0] period_reg;
  logic [`ISFM_LOS_W-1:0] miss_reg;
  logic loss_reg;
  logic edge_seen;
  assign edge_seen = i_clk_lvl && !prev_reg;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= i_clk_lvl;
    end
  end
  // Period measurement: each edge restarts the count
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      period_reg <= 8'h00;
    end else if (edge_seen || period_reg >= i_period_max) begin
      period_reg <= 8'h00;
    end else begin
      period_reg <= period_reg + 8'h01;
    end
  end
  // Missing edges counted against the tolerance
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      miss_reg <= '0;
      loss_reg <= 1'b1;
    end else if (i_disable) begin
      miss_reg <= '0;
      loss_reg <= 1'b0;
    end else if (edge_seen) begin
      miss_reg <= '0;
      loss_reg <= 1'b0;
    end else if (period_reg >= i_period_max) begin
      if (miss_reg >= i_miss_tol) begin
        loss_reg <= 1'b1;
      end else begin
        miss_reg <= miss_reg + 1'b1;
      end
    end
  end
  assign o_loss = loss_reg;
  property p_disabled_clear;
    @(posedge i_mclk) disable iff (!i_arst_n) i_disable |=> !o_loss;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear) else $error("disabled monitor flagged loss");
endmodule

// ==== isfm_pkg.sv ====
package isfm_pkg;
  typedef enum logic [4:0] {
    ISFM_FREERUN  = 5'h01,
    ISFM_FREEZE   = 5'h02,
    ISFM_ACQUIRE  = 5'h04,
    ISFM_LOCKED   = 5'h08,
    ISFM_HOLDOVER = 5'h10
  } isfm_mode_t;
  typedef logic [1:0] isfm_sel_t;
endpackage

// ==== isfm_sticky.sv ====
`timescale 1ns/100ps
`include "isfm_defines.svh"
module isfm_sticky (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Flag
  input wire logic i_live,
  input wire logic i_clear,
  output logic o_sticky
);
  logic sticky_reg;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sticky_reg <= 1'b0;
    end else if (i_live) begin
      sticky_reg <= 1'b1;
    end else if (i_clear) begin
      sticky_reg <= 1'b0;
    end
  end
  assign o_sticky = sticky_reg;
  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  property p_set_wins;
    @(posedge i_mclk) disable iff (!i_arst_n) i_live |=> o_sticky;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("sticky missed a set");
  property p_holds;
    @(posedge i_mclk) disable iff (!i_arst_n) (o_sticky && !i_clear) |=> o_sticky;
  endproperty
  a_holds: assert property (p_holds) else $error("sticky dropped without clear");
endmodule

// ==== isfm_top.sv ====
`timescale 1ns/100ps
`include "isfm_defines.svh"
// Behaviour
// - Any of four inputs routes to the single PLL clock through the input selector.
// - Config bit picks pin or register manual select; pins after reset.
// - Manual code 0..3 picks input 0..3 when zero delay is off.
// - Zero delay makes input 3 feedback; code 3 then reserved.
// - Manual choice without clock drops PLL to holdover, or to freeze without history.
// - Automatic selection uses only valid inputs, by priority and revertive setting.
// - Automatic mode with no valid input enters holdover, or freeze without history.
// - Revertive: always highest-priority valid input, switching when one appears.
// - Non-revertive: keep active input while valid, else best remaining.
// - Hitless switch absorbs phase between locked inputs, down to 7.68 MHz.
// - Ramped switching ramps frequency linearly using holdover-exit ramp rate.
// - Switch up to 40 ppm apart smoothly, normal or fastlock bandwidth.
// - Lock-loss indicator asserted throughout pull-in to a new input.
// - Every input monitored for loss and frequency; oscillator for loss.
// - Per-input loss monitors measure periods, have sensitivity and disable.
// - Loss status readable live and sticky until software clears.
// - Outputs disabled on oscillator loss unless configured to keep running.
// - Frequency reference selectable: oscillator or any of four inputs.
// - Out-of-range status combines precision and fast monitors, each disableable.
// - Precision monitor range up to 511 ppm in 1/16 steps, with hysteresis.
// - Fast monitor flags errors over threshold between 1000 and 16000 ppm.
// - No valid input and no holdover history gives frozen oscillator operation.
module isfm_top
  import isfm_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Clock inputs sampled as levels
  input wire logic [3:0] i_in_clk,
  input wire logic i_xo_clk,
  // Input selection
  input wire logic [1:0] i_sel_pins,
  input wire logic [1:0] i_sel_reg,
  input wire logic i_sel_from_reg,
  input wire logic i_auto_en,
  input wire logic i_revertive,
  input wire logic i_zero_delay,
  input wire logic [7:0] i_priority,
  // Switching options
  input wire logic i_hitless_en,
  input wire logic i_ramp_en,
  input wire logic i_fastlock_en,
  input wire logic i_locked,
  input wire logic i_history_valid,
  // Loss monitor configuration
  input wire logic [4:0] i_los_disable,
  input wire logic [7:0] i_los_period,
  input wire logic [`ISFM_LOS_W-1:0] i_los_tol,
  // Frequency monitor configuration and measured errors
  input wire logic [2:0] i_ref_sel,
  input wire logic i_prec_disable,
  input wire logic i_fast_disable,
  input wire logic [`ISFM_PREC_W-1:0] i_prec_assert,
  input wire logic [`ISFM_PREC_W-1:0] i_prec_hyst,
  input wire logic [`ISFM_FAST_W-1:0] i_fast_thr,
  input wire logic [4*`ISFM_ERR_W-1:0] i_freq_err,
  input wire logic i_err_valid,
  // Output control
  input wire logic i_out_on_xo_loss,
  // Sticky clears
  input wire logic [4:0] i_los_clear,
  input wire logic [3:0] i_oof_clear,
  // Selection results
  output isfm_pkg::isfm_sel_t o_active_sel,
  output isfm_pkg::isfm_mode_t o_mode,
  output logic o_pll_clk,
  output logic o_hitless,
  output logic o_ramp,
  output logic o_fastlock,
  output logic o_lock_loss,
  // Status
  output logic [4:0] o_los_live,
  output logic [4:0] o_los_sticky,
  output logic [3:0] o_oof_live,
  output logic [3:0] o_oof_sticky,
  output logic o_out_enable
);
  // ---------------------------------------------
  // Functions
  // ---------------------------------------------
  function automatic logic [1:0] prio_of(input logic [7:0] p, input logic [1:0] idx);
    prio_of = p[2*idx +: 2];
  endfunction
  function automatic logic [`ISFM_PREC_W-1:0] clamp_prec(input logic [`ISFM_PREC_W-1:0] v);
    clamp_prec = (v > `ISFM_PREC_MAX) ? `ISFM_PREC_MAX : v;
  endfunction
  function automatic logic [`ISFM_FAST_W-1:0] clamp_fast(input logic [`ISFM_FAST_W-1:0] v);
    if (v < `ISFM_FAST_MIN) begin
      clamp_fast = `ISFM_FAST_MIN;
    end else if (v > `ISFM_FAST_MAX) begin
      clamp_fast = `ISFM_FAST_MAX;
    end else begin
      clamp_fast = v;
    end
  endfunction
  // ---------------------------------------------
  // Loss monitors
  // ---------------------------------------------
  logic [4:0] clk_lvl;
  logic [4:0] loss;
  assign clk_lvl = {i_xo_clk, i_in_clk};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_los
      isfm_los_mon u_los (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_clk_lvl(clk_lvl[gi]),
        .i_disable(i_los_disable[gi]),
        .i_period_max(i_los_period),
        .i_miss_tol(i_los_tol),
        .o_loss(loss[gi])
      );
      isfm_sticky u_los_st (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_live(loss[gi]),
        .i_clear(i_los_clear[gi]),
        .o_sticky(o_los_sticky[gi])
      );
    end
  endgenerate
  assign o_los_live = loss;
  // ---------------------------------------------
  // Frequency monitors
  // ---------------------------------------------
  logic [3:0] prec_reg;
  logic [3:0] fast_flag;
  logic [3:0] frequency_out_of_range_flag;
  logic [`ISFM_ERR_W-1:0] ref_err;
  logic [`ISFM_PREC_W-1:0] prec_thr;
  logic [`ISFM_FAST_W-1:0] fast_thr;
  assign prec_thr = clamp_prec(i_prec_assert);
  assign fast_thr = clamp_fast(i_fast_thr);
  // Errors arrive against the oscillator; an input reference is subtracted
  always_comb begin
    ref_err = '0;
    if (i_ref_sel != `ISFM_REFSEL_XO) begin
      ref_err = i_freq_err[i_ref_sel[1:0]*`ISFM_ERR_W +: `ISFM_ERR_W];
    end
  end
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_oof
      logic signed [`ISFM_ERR_W:0] diff;
      logic [`ISFM_ERR_W:0] mag;
      logic [`ISFM_ERR_W:0] ppm;
      assign diff = $signed({i_freq_err[gi*`ISFM_ERR_W+`ISFM_ERR_W-1], i_freq_err[gi*`ISFM_ERR_W +: `ISFM_ERR_W]})
        - $signed({ref_err[`ISFM_ERR_W-1], ref_err});
      assign mag = diff[`ISFM_ERR_W] ? (~diff + 1'b1) : diff;
      assign ppm = {4'h0, mag[`ISFM_ERR_W:4]};
      always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          prec_reg[gi] <= 1'b0;
        end else if (i_prec_disable) begin
          prec_reg[gi] <= 1'b0;
        end else if (i_err_valid) begin
          if (mag > {8'h00, prec_thr}) begin
            prec_reg[gi] <= 1'b1;
          end else if ({1'b0, mag} + {9'h000, i_prec_hyst} < {1'b0, 8'h00, prec_thr}) begin
            prec_reg[gi] <= 1'b0;
          end
        end
      end
      assign fast_flag[gi] = !i_fast_disable && (ppm > {7'h00, fast_thr});
      assign frequency_out_of_range_flag[gi] = prec_reg[gi] | fast_flag[gi];
      isfm_sticky u_oof_st (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_live(frequency_out_of_range_flag[gi]),
        .i_clear(i_oof_clear[gi]),
        .o_sticky(o_oof_sticky[gi])
      );
    end
  endgenerate
  assign o_oof_live = frequency_out_of_range_flag;
  // ---------------------------------------------
  // Input selection
  // ---------------------------------------------
  logic [3:0] valid;
  logic [3:0] selectable;
  logic [1:0] manual_sel;
  logic manual_ok;
  logic [1:0] best_sel;
  logic best_found;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic have_input;
  logic switch_evt;
  assign valid = ~loss[3:0] & ~frequency_out_of_range_flag;
  assign selectable = valid & (i_zero_delay ? 4'h7 : 4'hF);
  assign manual_sel = i_sel_from_reg ? i_sel_reg : i_sel_pins;
  assign manual_ok = !(i_zero_delay && manual_sel == `ISFM_SEL_RESERVED);
  // Lower priority value wins; ties go to the lower index
  always_comb begin
    best_sel = 2'h0;
    best_found = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (selectable[k] && (!best_found || prio_of(i_priority, 2'(k)) < prio_of(i_priority, best_sel))) begin
        best_sel = 2'(k);
        best_found = 1'b1;
      end
    end
  end
  always_comb begin
    sel_next = sel_reg;
    if (!i_auto_en) begin
      if (manual_ok) begin
        sel_next = manual_sel;
      end
    end else if (i_revertive) begin
      if (best_found) begin
        sel_next = best_sel;
      end
    end else if (!selectable[sel_reg] && best_found) begin
      sel_next = best_sel;
    end
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_reg <= 2'h0;
    end else begin
      sel_reg <= sel_next;
    end
  end
  assign switch_evt = sel_next != sel_reg;
  assign have_input = i_auto_en ? best_found : (manual_ok && selectable[sel_reg]);
  assign o_active_sel = sel_reg;
  assign o_pll_clk = i_in_clk[sel_reg];
  // ---------------------------------------------
  // Operating mode
  // ---------------------------------------------
  isfm_mode_t mode_reg;
  logic pull_reg;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_reg <= ISFM_FREERUN;
    end else begin
      case (mode_reg)
        ISFM_FREERUN: begin
          if (have_input) begin
            mode_reg <= ISFM_ACQUIRE;
          end
        end
        ISFM_ACQUIRE, ISFM_LOCKED: begin
          if (!have_input) begin
            mode_reg <= i_history_valid ? ISFM_HOLDOVER : ISFM_FREEZE;
          end else if (switch_evt) begin
            mode_reg <= ISFM_ACQUIRE;
          end else if (i_locked) begin
            mode_reg <= ISFM_LOCKED;
          end
        end
        ISFM_HOLDOVER, ISFM_FREEZE: begin
          if (have_input) begin
            mode_reg <= ISFM_ACQUIRE;
          end
        end
        default: begin
          mode_reg <= ISFM_FREERUN;
        end
      endcase
    end
  end
  // Pull-in after a switch lasts until the loop reports lock
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pull_reg <= 1'b0;
    end else if (switch_evt) begin
      pull_reg <= 1'b1;
    end else if (i_locked) begin
      pull_reg <= 1'b0;
    end
  end
  assign o_mode = mode_reg;
  assign o_lock_loss = (mode_reg != ISFM_LOCKED) || pull_reg;
  assign o_hitless = i_hitless_en;
  assign o_ramp = i_ramp_en && (pull_reg || mode_reg == ISFM_ACQUIRE);
  assign o_fastlock = i_fastlock_en && (mode_reg == ISFM_ACQUIRE);
  assign o_out_enable = !loss[4] || i_out_on_xo_loss;
  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  property p_auto_holdover;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_auto_en && !best_found && i_history_valid && mode_reg == ISFM_LOCKED) |=> mode_reg == ISFM_HOLDOVER;
  endproperty
  a_auto_holdover: assert property (p_auto_holdover) else $error("no holdover without valid input");
  property p_freeze;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (!have_input && !i_history_valid && mode_reg == ISFM_ACQUIRE) |=> mode_reg == ISFM_FREEZE;
  endproperty
  a_freeze: assert property (p_freeze) else $error("no freeze without history");
  property p_revert;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_auto_en && i_revertive && best_found) |=> sel_reg == $past(best_sel);
  endproperty
  a_revert: assert property (p_revert) else $error("revertive not on best input");
  property p_nonrevert;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_auto_en && !i_revertive && selectable[sel_reg]) |=> $stable(sel_reg);
  endproperty
  a_nonrevert: assert property (p_nonrevert) else $error("non-revertive left a valid input");
  property p_zd_never3;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_auto_en && i_zero_delay) |=> (sel_reg != `ISFM_FB_INPUT || !$past(best_found));
  endproperty
  a_zd_never3: assert property (p_zd_never3) else $error("feedback input selected");
  property p_manual;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (!i_auto_en && !i_zero_delay) |=> sel_reg == $past(manual_sel);
  endproperty
  a_manual: assert property (p_manual) else $error("manual select not followed");
  property p_lol_pull;
    @(posedge i_mclk) disable iff (!i_arst_n) switch_evt |=> o_lock_loss;
  endproperty
  a_lol_pull: assert property (p_lol_pull) else $error("lock loss low during pull-in");
  property p_xo_out;
    @(posedge i_mclk) disable iff (!i_arst_n) (loss[4] && !i_out_on_xo_loss) |-> !o_out_enable;
  endproperty
  a_xo_out: assert property (p_xo_out) else $error("outputs on during oscillator loss");
  property p_sel_src;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (!i_auto_en && i_sel_from_reg && !i_zero_delay) |=> sel_reg == $past(i_sel_reg);
  endproperty
  a_sel_src: assert property (p_sel_src) else $error("register select ignored");
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
  import isfm_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int LOSS_T = 30;
  logic i_mclk = 1'h0;
  logic i_arst_n = 1'h0;
  logic [4:0] run = 5'h1F, los_dis = 5'h00, los_clear = 5'h00, los_live, los_sticky;
  logic [3:0] in_clk, oof_clear = 4'h0, oof_live, oof_sticky;
  logic [1:0] sel_pins = 2'h0, sel_reg = 2'h0;
  logic sel_from_reg = 1'h0, auto_en = 1'h0, revertive = 1'h0, zero_delay = 1'h0, xo_clk;
  logic hitless_en = 1'h0, ramp_en = 1'h1, fastlock_en = 1'h1, locked = 1'h0, history_valid = 1'h0;
  logic prec_dis = 1'h0, fast_dis = 1'h0, err_valid = 1'h0, out_on_xo = 1'h0;
  logic [12:0] prec_assert = 13'h03C0;
  logic [13:0] fast_thr = 14'h03E8;
  logic [79:0] freq_err = 80'h0;
  isfm_sel_t act_sel;
  isfm_mode_t mode;
  logic pll_clk, hitless, ramp, fastlock, lock_loss, out_en;
  int n_errors = 0;
  int n_compared = 0;

  always #4 i_mclk = ~i_mclk;

  isfm_clk_src src_u (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_run(run), .o_in_clk(in_clk), .o_xo_clk(xo_clk));
  isfm_top dut_u (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_in_clk(in_clk), .i_xo_clk(xo_clk),
    .i_sel_pins(sel_pins), .i_sel_reg(sel_reg), .i_sel_from_reg(sel_from_reg), .i_auto_en(auto_en),
    .i_revertive(revertive), .i_zero_delay(zero_delay), .i_priority(8'hD2),
    .i_hitless_en(hitless_en), .i_ramp_en(ramp_en), .i_fastlock_en(fastlock_en), .i_locked(locked),
    .i_history_valid(history_valid), .i_los_disable(los_dis), .i_los_period(8'h08), .i_los_tol(4'h1),
    .i_ref_sel(3'h4), .i_prec_disable(prec_dis), .i_fast_disable(fast_dis), .i_prec_assert(prec_assert),
    .i_prec_hyst(13'h0020), .i_fast_thr(fast_thr), .i_freq_err(freq_err), .i_err_valid(err_valid),
    .i_out_on_xo_loss(out_on_xo), .i_los_clear(los_clear), .i_oof_clear(oof_clear),
    .o_active_sel(act_sel), .o_mode(mode), .o_pll_clk(pll_clk), .o_hitless(hitless), .o_ramp(ramp),
    .o_fastlock(fastlock), .o_lock_loss(lock_loss), .o_los_live(los_live), .o_los_sticky(los_sticky),
    .o_oof_live(oof_live), .o_oof_sticky(oof_sticky), .o_out_enable(out_en)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic chk_flag(input logic [4:0] got, input logic [4:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_sel(input isfm_sel_t exp);
    chk_flag({3'h0, act_sel}, {3'h0, exp}, "active input");
  endtask

  task automatic chk_mode(input isfm_mode_t exp);
    chk_flag(mode, exp, "mode");
  endtask

  task automatic strobe(input logic [79:0] e);
    @(posedge i_mclk);
    freq_err <= e;
    err_valid <= 1'h1;
    @(posedge i_mclk);
    err_valid <= 1'h0;
    step(3);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_manual();
    for (int c = 0; c < 4; c++) begin
      @(posedge i_mclk);
      sel_pins <= 2'(c);
      step(3);
      chk_sel(2'(c));
      repeat (4) begin
        chk_flag({4'h0, pll_clk}, {4'h0, in_clk[c]}, "pll clock");
        step(1);
      end
    end
    @(posedge i_mclk);
    sel_from_reg <= 1'h1;
    sel_reg <= 2'h1;
    step(3);
    chk_sel(2'h1);
    @(posedge i_mclk);
    zero_delay <= 1'h1;
    sel_reg <= 2'h3;
    step(3);
    chk_sel(2'h1);
    @(posedge i_mclk);
    zero_delay <= 1'h0;
    sel_reg <= 2'h0;
    history_valid <= 1'h1;
    run <= 5'h1E;
    step(LOSS_T);
    chk_flag({4'h0, mode === ISFM_FREERUN || mode === ISFM_HOLDOVER}, 5'h01, "manual no clock");
    run <= 5'h1F;
    history_valid <= 1'h0;
    step(12);
    $display("test manual done");
  endtask

  task automatic t_lock();
    @(posedge i_mclk);
    locked <= 1'h1;
    step(3);
    chk_mode(ISFM_LOCKED);
    chk_flag({4'h0, lock_loss}, 5'h00, "lock loss settled");
    @(posedge i_mclk);
    locked <= 1'h0;
    sel_reg <= 2'h2;
    step(3);
    chk_mode(ISFM_ACQUIRE);
    chk_flag({3'h0, fastlock, hitless}, 5'h02, "pull in options");
    chk_flag({4'h0, ramp}, 5'h01, "ramp during pull in");
    step(5);
    chk_flag({4'h0, lock_loss}, 5'h01, "lock loss pulling in");
    @(posedge i_mclk);
    locked <= 1'h1;
    hitless_en <= 1'h1;
    step(3);
    chk_flag({3'h0, hitless, lock_loss}, 5'h02, "locked again");
    $display("test lock done");
  endtask

  task automatic t_auto();
    @(posedge i_mclk);
    auto_en <= 1'h1;
    revertive <= 1'h1;
    step(3);
    chk_sel(2'h1);
    run <= 5'h1D;
    step(LOSS_T);
    chk_sel(2'h2);
    run <= 5'h1F;
    step(12);
    chk_sel(2'h1);
    revertive <= 1'h0;
    run <= 5'h1D;
    step(LOSS_T);
    chk_sel(2'h2);
    run <= 5'h1F;
    step(12);
    chk_sel(2'h2);
    history_valid <= 1'h1;
    run <= 5'h10;
    step(LOSS_T);
    chk_mode(ISFM_HOLDOVER);
    run <= 5'h1F;
    step(12);
    history_valid <= 1'h0;
    run <= 5'h10;
    step(LOSS_T);
    chk_mode(ISFM_FREEZE);
    run <= 5'h1F;
    auto_en <= 1'h0;
    step(12);
    $display("test auto done");
  endtask

  task automatic t_los();
    @(posedge i_mclk);
    los_clear <= 5'h1F;
    @(posedge i_mclk);
    los_clear <= 5'h00;
    run <= 5'h1B;
    step(LOSS_T);
    chk_flag(los_live, 5'h04, "loss live");
    chk_flag(los_sticky, 5'h04, "loss sticky");
    los_clear <= 5'h04;
    step(3);
    chk_flag(los_sticky, 5'h04, "sticky under clear");
    run <= 5'h1F;
    step(12);
    chk_flag({los_live[2], los_sticky[2]}, 5'h00, "loss recovered and cleared");
    los_clear <= 5'h00;
    los_dis <= 5'h04;
    run <= 5'h1B;
    step(LOSS_T);
    chk_flag({4'h0, los_live[2]}, 5'h00, "disabled monitor");
    run <= 5'h0F;
    los_dis <= 5'h00;
    step(LOSS_T);
    chk_flag({3'h0, los_live[4], out_en}, 5'h02, "oscillator loss");
    out_on_xo <= 1'h1;
    step(2);
    chk_flag({4'h0, out_en}, 5'h01, "outputs kept");
    run <= 5'h1F;
    out_on_xo <= 1'h0;
    step(12);
    $display("test loss done");
  endtask

  task automatic t_oof();
    @(posedge i_mclk);
    fast_dis <= 1'h1;
    strobe({40'h0, 20'hFF9C0, 20'h0});
    chk_flag({1'h0, oof_live}, 5'h02, "precision flag");
    strobe(80'h0);
    chk_flag({oof_live, 1'h0}, 5'h00, "precision cleared");
    chk_flag({1'h0, oof_sticky}, 5'h02, "oof sticky");
    oof_clear <= 4'h2;
    step(2);
    chk_flag({1'h0, oof_sticky}, 5'h00, "oof sticky cleared");
    oof_clear <= 4'h0;
    prec_dis <= 1'h1;
    fast_dis <= 1'h0;
    strobe({40'h0, 20'h4E200, 20'h0});
    chk_flag({1'h0, oof_live}, 5'h02, "fast flag");
    fast_dis <= 1'h1;
    step(2);
    chk_flag({1'h0, oof_live}, 5'h00, "both monitors off");
    $display("test frequency done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'h1;
    step(12);
    t_manual();
    t_lock();
    t_auto();
    t_los();
    t_oof();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    close_out();
  end
endmodule
